// >>> design/tcc_defines.vh
// Register offsets, field positions, reset values and codes for the channel-one capture block
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// Register byte addresses (word aligned)
`define TCC_ADDR_MODE 8'h18
`define TCC_ADDR_ENABLE 8'h20
`define TCC_ADDR_COUNTER 8'h24
`define TCC_ADDR_CAPTURE 8'h34

// Mode register fields
`define TCC_MODE_DIR_LO 0
`define TCC_MODE_DIR_HI 1
`define TCC_MODE_DIV_LO 2
`define TCC_MODE_DIV_HI 3
`define TCC_MODE_FLT_LO 4
`define TCC_MODE_FLT_HI 7
`define TCC_MODE_MASK 16'h00ff

// Enable register fields
`define TCC_EN_BIT 0
`define TCC_POL_BIT 1
`define TCC_NEN_BIT 2
`define TCC_NPOL_BIT 3
`define TCC_EN_MASK 16'h000f

// Reset values
`define TCC_MODE_RESET 16'h0000
`define TCC_EN_RESET 16'h0000
`define TCC_CAPT_RESET 16'h0000

// Direction codes
`define TCC_DIR_OUTPUT 2'h0
`define TCC_DIR_IN_ONE 2'h1
`define TCC_DIR_IN_TWO 2'h2
`define TCC_DIR_IN_TRIG 2'h3

// Polarity pair codes in input mode
`define TCC_POLPAIR_RISE 2'h0
`define TCC_POLPAIR_FALL 2'h1
`define TCC_POLPAIR_BOTH 2'h3

// Lock levels that freeze the complementary polarity
`define TCC_LOCK_TWO 2'h2
`define TCC_LOCK_THREE 2'h3

// Filter off code
`define TCC_FLT_OFF 4'h0

`endif

// >>> design/tcc_filter.v
// Sampling digital filter: passes a level after N agreeing samples
`timescale 1ns/1ps
module tcc_filter #(
  parameter CNT_W = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Control
  input wire sample_en,
  input wire bypass,
  input wire [CNT_W-1:0] need_len,
  // Data
  input wire din,
  output reg dout
);

  reg [CNT_W-1:0] agree;

  // Count consecutive samples that differ from the held output
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'b0;
      agree <= {CNT_W{1'b0}};
    end else if (bypass) begin
      dout <= din;
      agree <= {CNT_W{1'b0}};
    end else if (sample_en) begin
      if (din == dout) begin
        agree <= {CNT_W{1'b0}};
      end else if (agree + 1'b1 >= need_len) begin
        // With bypass off, only a full run of N new-level samples flips the output
        dout <= din;
        agree <= {CNT_W{1'b0}};
      end else begin
        agree <= agree + 1'b1;
      end
    end
  end

endmodule // tcc_filter

// >>> design/tcc_capture_ch1.v
// Timer channel-one capture/compare configuration with Avalon-MM register slave
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_capture_ch1 #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [1:0] avs_response,
  // Timer core links
  input wire [CNT_W-1:0] counter_value,
  input wire [1:0] lock_level,
  input wire dts_tick,
  input wire chan_ref_level,
  input wire internal_trigger_source,
  // Pins
  input wire timer_input_one,
  input wire timer_input_two,
  output reg chan_output_pin,
  output reg chan_output_pin_oe,
  output reg chan_complementary_pin,
  output reg chan_complementary_pin_oe,
  // Capture status
  output reg capture_event,
  output reg [CNT_W-1:0] chan_capture_value_reg,
  output wire [1:0] filtered_polarized_input
);

  // Register storage
  reg [15:0] channel_mode_input_config;
  reg [15:0] channel_enable_polarity;
  reg ack;

  // Fields
  wire [1:0] chan_direction_select = channel_mode_input_config[`TCC_MODE_DIR_HI:`TCC_MODE_DIR_LO];
  wire [1:0] capture_event_divider = channel_mode_input_config[`TCC_MODE_DIV_HI:`TCC_MODE_DIV_LO];
  wire [3:0] input_filter_setting = channel_mode_input_config[`TCC_MODE_FLT_HI:`TCC_MODE_FLT_LO];
  wire chan_output_capture_enable = channel_enable_polarity[`TCC_EN_BIT];
  wire chan_polarity = channel_enable_polarity[`TCC_POL_BIT];
  wire complementary_output_enable = channel_enable_polarity[`TCC_NEN_BIT];
  wire complementary_polarity = channel_enable_polarity[`TCC_NPOL_BIT];
  wire is_output = (chan_direction_select == `TCC_DIR_OUTPUT);

  // One-cycle wait on every access gives the master a registered answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  wire take = (avs_read | avs_write) & ack;
  wire wr_lo = avs_write & take & avs_byteenable[0];
  wire hit_mode = (avs_address == `TCC_ADDR_MODE);
  wire hit_en = (avs_address == `TCC_ADDR_ENABLE);
  wire hit_cnt = (avs_address == `TCC_ADDR_COUNTER);
  wire hit_cap = (avs_address == `TCC_ADDR_CAPTURE);
  wire mapped = hit_mode | hit_en | hit_cnt | hit_cap;

  // Access acknowledge toggles so each request spends exactly one wait cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // Mode register writes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_mode_input_config <= `TCC_MODE_RESET;
    end else if (wr_lo && hit_mode) begin
      channel_mode_input_config[`TCC_MODE_FLT_HI:`TCC_MODE_DIV_LO] <=
        avs_writedata[`TCC_MODE_FLT_HI:`TCC_MODE_DIV_LO];
      if (!chan_output_capture_enable) begin
        channel_mode_input_config[`TCC_MODE_DIR_HI:`TCC_MODE_DIR_LO] <=
          avs_writedata[`TCC_MODE_DIR_HI:`TCC_MODE_DIR_LO];
      end
    end
  end

  // Enable/polarity register writes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_enable_polarity <= `TCC_EN_RESET;
    end else if (wr_lo && hit_en) begin
      channel_enable_polarity[`TCC_EN_BIT] <= avs_writedata[`TCC_EN_BIT];
      channel_enable_polarity[`TCC_POL_BIT] <= avs_writedata[`TCC_POL_BIT];
      channel_enable_polarity[`TCC_NEN_BIT] <= avs_writedata[`TCC_NEN_BIT];
      if (lock_level != `TCC_LOCK_TWO && lock_level != `TCC_LOCK_THREE) begin
        channel_enable_polarity[`TCC_NPOL_BIT] <= avs_writedata[`TCC_NPOL_BIT];
      end
    end
  end

  // Read data and response, registered at the edge that ends the wait cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else if ((avs_read | avs_write) && !ack) begin
      avs_response <= mapped ? 2'h0 : 2'h3;
      if (hit_mode) begin
        avs_readdata <= {16'h0000, channel_mode_input_config & `TCC_MODE_MASK};
      end else if (hit_en) begin
        avs_readdata <= {16'h0000, channel_enable_polarity & `TCC_EN_MASK};
      end else if (hit_cnt) begin
        avs_readdata <= {{(32-CNT_W){1'b0}}, counter_value};
      end else if (hit_cap) begin
        avs_readdata <= {{(32-CNT_W){1'b0}}, chan_capture_value_reg};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Pin synchronisers; first stage feeds only the second
  reg [1:0] sync_a;
  reg [1:0] sync_b;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end else begin
      sync_a <= {timer_input_two, timer_input_one};
      sync_b <= sync_a;
    end
  end

  // Filter table lookup
  reg [5:0] samp_div;
  reg [3:0] flt_len;
  always @* begin
    case (input_filter_setting)
      4'h1: begin samp_div = 6'h01; flt_len = 4'h2; end
      4'h2: begin samp_div = 6'h01; flt_len = 4'h4; end
      4'h3: begin samp_div = 6'h01; flt_len = 4'h8; end
      4'h4: begin samp_div = 6'h02; flt_len = 4'h6; end
      4'h5: begin samp_div = 6'h02; flt_len = 4'h8; end
      4'h6: begin samp_div = 6'h04; flt_len = 4'h6; end
      4'h7: begin samp_div = 6'h04; flt_len = 4'h8; end
      4'h8: begin samp_div = 6'h08; flt_len = 4'h6; end
      4'h9: begin samp_div = 6'h08; flt_len = 4'h8; end
      4'ha: begin samp_div = 6'h10; flt_len = 4'h5; end
      4'hb: begin samp_div = 6'h10; flt_len = 4'h6; end
      4'hc: begin samp_div = 6'h10; flt_len = 4'h8; end
      4'hd: begin samp_div = 6'h20; flt_len = 4'h5; end
      4'he: begin samp_div = 6'h20; flt_len = 4'h6; end
      4'hf: begin samp_div = 6'h20; flt_len = 4'h8; end
      default: begin samp_div = 6'h01; flt_len = 4'h1; end
    endcase
  end

  // Sample enable divider on the timer clock
  reg [5:0] div_cnt;
  wire div_tick = (div_cnt + 6'h01 >= samp_div);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 6'h00;
    end else if (div_tick) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  wire flt_off = (input_filter_setting == `TCC_FLT_OFF);
  wire samp_en = flt_off ? dts_tick : div_tick;
  wire [1:0] filt;
  // Bypassed filters follow the pin, so a later filter code starts from the live level

  // One filter per timer input
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_flt
      tcc_filter #(.CNT_W(4)) u_flt (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample_en(samp_en),
        .bypass(flt_off),
        .need_len(flt_len),
        .din(sync_b[gi]),
        .dout(filt[gi])
      );
    end
  endgenerate

  // Held sample when filtering is off, taken on the reference tick
  reg [1:0] ref_samp;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_samp <= 2'h0;
    end else if (dts_tick) begin
      ref_samp <= sync_b;
    end
  end
  wire [1:0] flt_out = flt_off ? ref_samp : filt;

  wire [1:0] pol_pair = {complementary_polarity, chan_polarity};
  assign filtered_polarized_input = (pol_pair == `TCC_POLPAIR_FALL) ? ~flt_out : flt_out;

  reg sel_in;
  always @* begin
    case (chan_direction_select)
      `TCC_DIR_IN_ONE: sel_in = filtered_polarized_input[0];
      `TCC_DIR_IN_TWO: sel_in = filtered_polarized_input[1];
      `TCC_DIR_IN_TRIG: sel_in = internal_trigger_source;
      default: sel_in = 1'b0;
    endcase
  end

  // Edge detection on the selected capture input
  reg sel_d;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_d <= 1'b0;
    end else begin
      sel_d <= sel_in;
    end
  end
  wire rise = sel_in & ~sel_d;
  wire fall = ~sel_in & sel_d;
  // edge choice; inverted signal's rise is a pin fall
  wire edge_hit = (pol_pair == `TCC_POLPAIR_BOTH) ? (rise | fall) : rise;
  wire chan_capture_input = edge_hit & ~is_output;

  reg [2:0] ev_cnt;
  wire [2:0] ev_lim = (3'h1 << capture_event_divider) - 3'h1;
  wire div_done = (ev_cnt >= ev_lim);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_cnt <= 3'h0;
    end else if (is_output || !chan_output_capture_enable) begin
      ev_cnt <= 3'h0;
    end else if (chan_capture_input) begin
      ev_cnt <= div_done ? 3'h0 : ev_cnt + 3'h1;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_capture_value_reg <= `TCC_CAPT_RESET;
      capture_event <= 1'b0;
    end else begin
      capture_event <= chan_capture_input & div_done & chan_output_capture_enable;
      if (chan_capture_input && div_done && chan_output_capture_enable) begin
        chan_capture_value_reg <= counter_value;
      end
    end
  end

  // Output pins, registered
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_output_pin <= 1'b0;
      chan_output_pin_oe <= 1'b0;
      chan_complementary_pin <= 1'b0;
      chan_complementary_pin_oe <= 1'b0;
    end else begin
      chan_output_pin_oe <= is_output & chan_output_capture_enable;
      chan_output_pin <= chan_ref_level ^ chan_polarity;
      chan_complementary_pin_oe <= complementary_output_enable;
      chan_complementary_pin <= ~chan_ref_level ^ complementary_polarity;
    end
  end

endmodule // tcc_capture_ch1

// >>> verif/tcc_pin_model.sv
// Far-side model: timer input pins and the internal trigger level
`timescale 1ns/1ps
module tcc_pin_model (
  // Clock
  input wire sys_clk,
  // Capture sources
  output wire timer_input_one,
  output wire timer_input_two,
  output wire internal_trigger_source
);
  reg [2:0] lv = 3'h0;
  assign {internal_trigger_source, timer_input_two, timer_input_one} = lv;
  // Pulse train on one source; levels move just after an edge, idle level is low
  task automatic burst(input int sel, n, hi, lo);
    repeat (n) begin
      @(posedge sys_clk);
      lv[sel] <= 1'b1;
      repeat (hi) @(posedge sys_clk);
      lv[sel] <= 1'b0;
      repeat (lo) @(posedge sys_clk);
    end
  endtask
endmodule // tcc_pin_model

// >>> verif/tcc_ch1_checker.sv
// Assertion checker for the channel-one capture block, bound to its ports
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_ch1_checker #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Register bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [1:0] avs_response,
  // Core links and outputs
  input wire [CNT_W-1:0] counter_value,
  input wire [1:0] lock_level,
  input wire chan_output_pin_oe,
  input wire chan_complementary_pin_oe,
  input wire capture_event,
  input wire [CNT_W-1:0] chan_capture_value_reg
);
  reg [7:0] sh_mode;
  reg [3:0] sh_en;
  wire wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire rd_done = avs_read && !avs_waitrequest;
  wire mapped = avs_address == `TCC_ADDR_MODE || avs_address == `TCC_ADDR_ENABLE ||
    avs_address == `TCC_ADDR_COUNTER || avs_address == `TCC_ADDR_CAPTURE;
  // Shadow of both registers, honouring the write refusals
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_mode <= 8'h00;
      sh_en <= 4'h0;
    end else if (wr_done && avs_address == `TCC_ADDR_ENABLE) begin
      sh_en <= {lock_level[1] ? sh_en[3] : avs_writedata[3], avs_writedata[2:0]};
    end else if (wr_done && avs_address == `TCC_ADDR_MODE) begin
      sh_mode <= {avs_writedata[7:2], sh_en[0] ? sh_mode[1:0] : avs_writedata[1:0]};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_wait_one_cycle: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait not one cycle");
  a_resp_code: assert property ((avs_read || avs_write) && !avs_waitrequest |->
    avs_response == (mapped ? 2'h0 : 2'h3)) else $error("bad response");
  a_enable_readback: assert property (rd_done && avs_address == `TCC_ADDR_ENABLE |->
    avs_readdata == {28'h0, sh_en}) else $error("enable readback");
  a_mode_readback: assert property (rd_done && avs_address == `TCC_ADDR_MODE |->
    avs_readdata == {24'h0, sh_mode}) else $error("mode readback");
  a_out_enable: assert property (chan_output_pin_oe ==
    $past(sh_en[0] && sh_mode[1:0] == `TCC_DIR_OUTPUT)) else $error("output enable");
  a_comp_enable: assert property (chan_complementary_pin_oe == $past(sh_en[2]))
    else $error("complementary enable");
  a_capture_gate: assert property (capture_event |->
    sh_en[0] && sh_mode[1:0] != `TCC_DIR_OUTPUT) else $error("capture not gated");
  a_capture_value: assert property (capture_event |->
    chan_capture_value_reg == $past(counter_value)) else $error("capture value");
  c_capture: cover property (capture_event);
  c_output: cover property (chan_output_pin_oe);
  c_unmapped: cover property (rd_done && !mapped);
endmodule // tcc_ch1_checker
bind tcc_capture_ch1 tcc_ch1_checker #(.CNT_W(CNT_W)) chk_i (.*);

// >>> verif/tcc_capture_ch1_tb.sv
// Self-checking bench for the channel-one capture configuration block
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_capture_ch1_tb;
  logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, dts_tick, chan_ref_level;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response, lock_level, filtered_polarized_input;
  logic timer_input_one, timer_input_two, internal_trigger_source, capture_event;
  logic chan_output_pin, chan_output_pin_oe, chan_complementary_pin, chan_complementary_pin_oe;
  logic [15:0] counter_value, chan_capture_value_reg, cap_exp;
  int mismatches = 0, checked = 0, caps = 0;
  tcc_capture_ch1 uut (.*);
  tcc_pin_model pins (.*);
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Free-running count, half-rate sampling tick and capture tally
  always @(posedge sys_clk) begin
    counter_value <= counter_value + 16'h1;
    dts_tick <= ~dts_tick;
    // A stored capture holds the count of the cycle before its pulse
    if (capture_event === 1'b1) begin
      caps <= caps + 1;
      cap_exp <= counter_value - 16'h1;
    end
  end
  task automatic give_verdict;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One bus transfer; request held until waitrequest is seen low, bounded wait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      chk(32'h0, 32'h1, "bus timeout");
      give_verdict();
    end
  endtask
  task automatic t_regs;
    bus(1'b0, `TCC_ADDR_ENABLE, 32'h0);
    chk(rd, 32'h0, "enable reset");
    // A write without lane zero must leave the register alone
    avs_byteenable <= 4'he;
    bus(1'b1, `TCC_ADDR_ENABLE, 32'hf);
    avs_byteenable <= 4'hf;
    bus(1'b0, `TCC_ADDR_ENABLE, 32'h0);
    chk(rd, 32'h0, "lane zero off");
    bus(1'b0, 8'h04, 32'h0);
    chk({30'h0, avs_response}, 32'h3, "unmapped");
    bus(1'b1, `TCC_ADDR_ENABLE, 32'h1);
    bus(1'b1, `TCC_ADDR_MODE, 32'h1);
    bus(1'b0, `TCC_ADDR_MODE, 32'h0);
    chk(rd, 32'h0, "dir locked");
    bus(1'b1, `TCC_ADDR_ENABLE, 32'hfff0);
    bus(1'b0, `TCC_ADDR_ENABLE, 32'h0);
    chk(rd, 32'h0, "enable reserved");
    bus(1'b1, `TCC_ADDR_MODE, 32'hffff);
    bus(1'b0, `TCC_ADDR_MODE, 32'h0);
    chk(rd, 32'hff, "mode reserved");
    bus(1'b1, `TCC_ADDR_MODE, 32'h0);
  endtask
  // Output mode: enable and polarity against both reference levels
  task automatic t_output;
    logic cp;
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 2; r++) begin
        chan_ref_level <= r[0];
        bus(1'b1, `TCC_ADDR_ENABLE, 32'h1 | (p << 1));
        repeat (3) @(posedge sys_clk);
        chk(chan_output_pin_oe, 32'h1, "oe");
        chk(chan_complementary_pin_oe, 32'h0, "comp oe off");
        chk(chan_output_pin, (r != p) ? 32'h1 : 32'h0, "level");
      end
    end
    chan_ref_level <= 1'b1;
    bus(1'b1, `TCC_ADDR_ENABLE, 32'h4);
    repeat (3) @(posedge sys_clk);
    chk(chan_output_pin_oe, 32'h0, "oe off");
    chk(chan_complementary_pin_oe, 32'h1, "comp oe");
    // Local copy: the write below changes chan_complementary_pin before the check
    cp = chan_complementary_pin;
    bus(1'b1, `TCC_ADDR_ENABLE, 32'hc);
    repeat (3) @(posedge sys_clk);
    chk(chan_complementary_pin, {31'h0, ~cp}, "comp pol");
    for (int lk = 2; lk < 4; lk++) begin
      lock_level <= lk[1:0];
      bus(1'b1, `TCC_ADDR_ENABLE, 32'h4);
      bus(1'b0, `TCC_ADDR_ENABLE, 32'h0);
      chk(rd, 32'hc, "pol locked");
    end
    lock_level <= 2'h0;
  endtask
  // Program the channel, send pulses, count stored captures
  task automatic run_caps(input logic [7:0] mode, input logic [3:0] en, input int sel, n,
    hi, lo, exp);
    int base;
    // Polarity is set while disabled, so its flip is never taken for a pin edge
    bus(1'b1, `TCC_ADDR_ENABLE, {28'h0, en & 4'he});
    bus(1'b1, `TCC_ADDR_MODE, {24'h0, mode});
    bus(1'b1, `TCC_ADDR_ENABLE, {28'h0, en});
    base = caps;
    pins.burst(sel, n, hi, lo);
    chk(caps - base, exp, "captures");
  endtask
  // pair 10 is reserved to software and never set
  task automatic t_prescale;
    int pr[3] = '{0, 1, 3};
    foreach (pr[i]) begin
      for (int s = 0; s < 4; s++) begin
        run_caps({4'h0, s[1:0], 2'h1}, {pr[i][1], 1'b0, pr[i][0], 1'b1}, 0, 8, 10, 10,
          (pr[i] == 3 ? 16 : 8) >> s);
        chk(filtered_polarized_input, pr[i] == 1 ? 32'h3 : 32'h0, "fpi");
      end
    end
  endtask
  task automatic t_sources;
    run_caps(8'h02, 4'h1, 1, 8, 10, 10, 8);
    // Stored value and the counter through the bus
    bus(1'b0, `TCC_ADDR_CAPTURE, 32'h0);
    chk(rd, {16'h0, cap_exp}, "capture value");
    chk(chan_capture_value_reg, {16'h0, cap_exp}, "capture port");
    bus(1'b0, `TCC_ADDR_COUNTER, 32'h0);
    chk(rd, {16'h0, counter_value - 16'h1}, "counter readback");
    run_caps(8'h03, 4'h1, 2, 8, 10, 10, 8);
    run_caps(8'h01, 4'h1, 1, 8, 10, 10, 0);
    run_caps(8'h01, 4'h0, 0, 8, 10, 10, 0);
    run_caps(8'h00, 4'h1, 0, 8, 10, 10, 0);
  endtask
  // Pulses just under and well over the filter span
  task automatic t_filter;
    int fc[4] = '{1, 3, 9, 15};
    int sh[4] = '{1, 6, 40, 200};
    int lg[4] = '{4, 12, 90, 300};
    foreach (fc[i]) begin
      run_caps({fc[i][3:0], 4'h1}, 4'h1, 0, 1, sh[i], lg[i], 0);
      run_caps({fc[i][3:0], 4'h1}, 4'h1, 0, 1, lg[i], lg[i], 1);
    end
  endtask
  // Main sequence
  initial begin
    {rst_n, avs_read, avs_write, dts_tick} = 4'h0;
    {avs_address, avs_writedata, lock_level, counter_value} = 58'h0;
    avs_byteenable = 4'hf;
    chan_ref_level = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_output();
    t_prescale();
    t_sources();
    t_filter();
    give_verdict();
  end
endmodule // tcc_capture_ch1_tb
